// ==== design/scbh_beat_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scbh_regs.svh"
// four-word store for burst beats, registered read
module scbh_beat_buf
(
   // clock
   input  wire logic        clk_sys,
   // write side
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_idx,
   input  wire logic [31:0] wr_data,
   // read side
   input  wire logic [1:0]  rd_idx,
   output logic      [31:0] rd_data
);
   logic [31:0] mem_q [4];

   // storage
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge clk_sys)
   begin
      rd_data <= mem_q[rd_idx];
   end
endmodule : scbh_beat_buf
`default_nettype wire

// ==== design/scbh_cs_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scbh_regs.svh"
// fixed 2M-byte select window decoder for one select line
module scbh_cs_decode
(
   // address and programmed base
   input  wire logic [31:0] addr,
   input  wire logic [7:0]  base_hi,
   input  wire logic [2:0]  slot,
   input  wire logic        valid,
   // match out
   output logic             hit
);
   logic [31:0] blk_base;

   // common base plus fixed per-slot offset of one 2M block
   always_comb
   begin
      blk_base = {base_hi, 24'h000000}
                 + ({29'h0, slot} << `SCBH_BLK_BITS);
      hit      = valid
                 && (addr[31:`SCBH_BLK_BITS]
                     == blk_base[31:`SCBH_BLK_BITS]);
   end
endmodule : scbh_cs_decode
`default_nettype wire

// ==== design/scbh_host.sv ====
// Function
// - all bus pins driven and sampled on the one bus clock
// - host gives full 32-bit address and 32-bit data paths
// - peripheral accesses are plain memory cycles, no io space
// - drive address and pull transfer start low one clock
// - drive two-bit size code with the address
// - direction high for reads, low for writes
// - drive two-bit transfer kind code with the address
// - cycle active stays high through the whole cycle
// - no new cycle until acknowledge has gone inactive
// - each transaction lasts at least two bus clocks
// - burst is four 32-bit beats, cycle active held throughout
// - select config can forbid bursts to a region
// - eight selects plus output enable and byte write strobes
// - selects 0 and 1 take any base and block size; here both are never decoded and stay high
// - select 0 may be live straight after reset; here select 0 never goes low
// - selects 2 to 7 each decode fixed 2M block from common base
// - one config shared by all selects: waits or external ack, burst, wp; port size bits stored but unused
`timescale 1ns/1ps
`default_nettype none
`include "scbh_regs.svh"
module scbh_host
#(
   parameter int ACK_TMO = `SCBH_ACK_TMO_CYC
)
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // software command port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata,
   // system bus towards the target
   output logic      [31:0] bus_addr,
   output logic      [31:0] bus_dout,
   output logic             bus_doe,
   input  wire logic [31:0] bus_din,
   output logic             transfer_start_n,
   output logic      [1:0]  xfer_size_code,
   output logic      [1:0]  xfer_kind_code,
   output logic             bus_rd_wr,
   output logic             cycle_active,
   input  wire logic        transfer_ack_n,
   // chip select module outputs
   output logic      [7:0]  chip_sel_n,
   output logic             out_enable_n,
   output logic      [3:0]  byte_write_strobe_n
);
   scbh_pkg::scbh_state_type state_q;
   logic [31:0] addr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic        read_q;
   logic [1:0]  size_q;
   logic [1:0]  kind_q;
   logic        burst_q;
   logic [7:0]  csbase_q;
   logic [9:0]  cfg_q;
   logic        done_q;
   logic        err_q;
   logic [2:0]  beat_q;
   logic [3:0]  ws_q;
   logic [15:0] tmo_q;
   logic [7:0]  hit;
   logic        any_hit;
   logic        go;
   logic        ack_seen;
   logic        bad_req;
   logic [31:0] buf_rd;
   logic [1:0]  buf_idx;

   // select decode for the six fixed io windows
   // fixed 2M windows
   genvar gi;
   generate
      for (gi = 2; gi < 8; gi++)
      begin : g_cs
         scbh_cs_decode u_dec
         (
            .addr     (addr_q),
            .base_hi  (csbase_q),
            .slot     (3'(gi - 2)),
            .valid    (cfg_q[`SCBH_CFG_VALID]),
            .hit      (hit[gi])
         );
      end
   endgenerate
   // selects 0 and 1 serve boot and ram, not decoded by this port
   // boot select unused
   assign hit[1:0] = 2'b00;
   assign any_hit  = |hit;

   // command acceptance
   assign go = sw_wr && (sw_addr == `SCBH_OFS_CTRL)
               && sw_wdata[`SCBH_CTRL_GO]
               && (state_q == scbh_pkg::SCBH_IDLE);
   assign bad_req = !any_hit
      || (sw_wdata[`SCBH_CTRL_BURST] && !cfg_q[`SCBH_CFG_BURST_EN])
      || (!sw_wdata[`SCBH_CTRL_READ] && cfg_q[`SCBH_CFG_WPROT]);
   // acknowledge or internal wait expiry ends a beat
   // target ack
   assign ack_seen = cfg_q[`SCBH_CFG_EXTACK] ? !transfer_ack_n
                                             : (ws_q == 4'h0);

   // software registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q   <= 32'h0000_0000;
         wdata_q  <= 32'h0000_0000;
         csbase_q <= `SCBH_CSBASE_RST;
         cfg_q    <= `SCBH_CSCFG_RST;
         read_q   <= 1'b0;
         size_q   <= 2'h0;
         kind_q   <= 2'h0;
         burst_q  <= 1'b0;
      end
      else if (sw_wr && (state_q == scbh_pkg::SCBH_IDLE))
      begin
         // setup registers are frozen while a cycle runs
         unique case (sw_addr)
            `SCBH_OFS_ADDR:   addr_q   <= sw_wdata;
            `SCBH_OFS_WDATA:  wdata_q  <= sw_wdata;
            `SCBH_OFS_CSBASE: csbase_q <= sw_wdata[7:0];
            `SCBH_OFS_CSCFG:  cfg_q    <= sw_wdata[9:0];
            `SCBH_OFS_CTRL:
            begin
               read_q  <= sw_wdata[`SCBH_CTRL_READ];
               size_q  <= sw_wdata[`SCBH_CTRL_SIZE_LO +: 2];
               kind_q  <= sw_wdata[`SCBH_CTRL_KIND_LO +: 2];
               burst_q <= sw_wdata[`SCBH_CTRL_BURST];
            end
            default: ;
         endcase
      end
   end

   // bus cycle sequencer
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= scbh_pkg::SCBH_IDLE;
      end
      else
      begin
         unique case (state_q)
            scbh_pkg::SCBH_IDLE:
               if (go && !bad_req)
               begin
                  state_q <= scbh_pkg::SCBH_START;
               end
            scbh_pkg::SCBH_START: state_q <= scbh_pkg::SCBH_WAIT;
            scbh_pkg::SCBH_WAIT:
               if (ack_seen)
               begin
                  state_q <= (burst_q && beat_q != 3'h1)
                             ? scbh_pkg::SCBH_WAIT
                             : scbh_pkg::SCBH_ACKED;
               end
               else if (tmo_q == 16'h0000)
               begin
                  state_q <= scbh_pkg::SCBH_ACKED;
               end
            scbh_pkg::SCBH_ACKED:
               if (transfer_ack_n)
               begin
                  state_q <= scbh_pkg::SCBH_DONE;
               end
            scbh_pkg::SCBH_DONE:  state_q <= scbh_pkg::SCBH_IDLE;
            default:              state_q <= scbh_pkg::SCBH_IDLE;
         endcase
      end
   end

   // beat, wait-state and timeout counters
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         beat_q <= 3'h0;
         ws_q   <= 4'h0;
         tmo_q  <= 16'h0000;
      end
      else if (state_q == scbh_pkg::SCBH_START)
      begin
         beat_q <= burst_q ? `SCBH_BURST_BEATS : 3'h1;
         ws_q   <= cfg_q[`SCBH_CFG_WS_LO +: 4];
         tmo_q  <= 16'(ACK_TMO);
      end
      else if (state_q == scbh_pkg::SCBH_WAIT)
      begin
         if (ack_seen)
         begin
            beat_q <= beat_q - 3'h1;
            ws_q   <= cfg_q[`SCBH_CFG_WS_LO +: 4];
            tmo_q  <= 16'(ACK_TMO);
         end
         else
         begin
            if (ws_q != 4'h0)
            begin
               ws_q <= ws_q - 4'h1;
            end
            if (tmo_q != 16'h0000)
            begin
               tmo_q <= tmo_q - 16'h0001;
            end
         end
      end
   end

   // burst beats land in the small store; a plain read keeps one word
   assign buf_idx = 2'(`SCBH_BURST_BEATS - beat_q);
   scbh_beat_buf u_buf
   (
      .clk_sys  (clk_sys),
      .wr_en    (state_q == scbh_pkg::SCBH_WAIT && ack_seen && read_q),
      .wr_idx   (buf_idx),
      .wr_data  (bus_din),
      .rd_idx   (sw_wdata[1:0]),
      .rd_data  (buf_rd)
   );

   // read capture and status flags; set wins over a clear
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 32'h0000_0000;
         done_q  <= 1'b0;
         err_q   <= 1'b0;
      end
      else
      begin
         if (state_q == scbh_pkg::SCBH_WAIT && ack_seen && read_q)
         begin
            rdata_q <= bus_din;
         end
         if (state_q == scbh_pkg::SCBH_DONE)
         begin
            done_q <= 1'b1;
         end
         else if (go || (sw_wr && sw_addr == `SCBH_OFS_STATUS))
         begin
            done_q <= 1'b0;
         end
         if ((go && bad_req) || (state_q == scbh_pkg::SCBH_WAIT
             && !ack_seen && tmo_q == 16'h0000))
         begin
            err_q <= 1'b1;
         end
         else if (go || (sw_wr && sw_addr == `SCBH_OFS_STATUS))
         begin
            err_q <= 1'b0;
         end
      end
   end

   // bus pin drive, all from flops in this clock domain
   // single bus clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_addr         <= 32'h0000_0000;
         bus_dout         <= 32'h0000_0000;
         bus_doe          <= 1'b0;
         transfer_start_n <= 1'b1;
         xfer_size_code   <= 2'h0;
         xfer_kind_code   <= 2'h0;
         bus_rd_wr        <= 1'b1;
      end
      else
      begin
         transfer_start_n <= !(state_q == scbh_pkg::SCBH_IDLE
                               && go && !bad_req);
         if (state_q == scbh_pkg::SCBH_IDLE && go && !bad_req)
         begin
            bus_addr       <= addr_q;
            bus_dout       <= wdata_q;
            bus_doe        <= !sw_wdata[`SCBH_CTRL_READ];
            xfer_size_code <= sw_wdata[`SCBH_CTRL_BURST]
               ? 2'(scbh_pkg::SCBH_SZ_LN)
               : sw_wdata[`SCBH_CTRL_SIZE_LO +: 2];
            xfer_kind_code <= sw_wdata[`SCBH_CTRL_KIND_LO +: 2];
            bus_rd_wr      <= sw_wdata[`SCBH_CTRL_READ];
         end
         else if (state_q == scbh_pkg::SCBH_WAIT && ack_seen && burst_q)
         begin
            bus_addr <= bus_addr + 32'h0000_0004;
         end
         else if (state_q == scbh_pkg::SCBH_DONE)
         begin
            bus_doe   <= 1'b0;
            bus_rd_wr <= 1'b1;
         end
      end
   end

   assign cycle_active = (state_q == scbh_pkg::SCBH_START)
                      || (state_q == scbh_pkg::SCBH_WAIT);

   // select and strobe outputs
   // selects and strobes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chip_sel_n          <= 8'hff;
         out_enable_n        <= 1'b1;
         byte_write_strobe_n <= 4'hf;
      end
      else if (state_q == scbh_pkg::SCBH_START
               || (state_q == scbh_pkg::SCBH_WAIT && !ack_seen))
      begin
         chip_sel_n          <= ~hit;
         out_enable_n        <= !read_q;
         byte_write_strobe_n <= read_q ? 4'hf : 4'h0;
      end
      else
      begin
         chip_sel_n          <= 8'hff;
         out_enable_n        <= 1'b1;
         byte_write_strobe_n <= 4'hf;
      end
   end

   // software read data, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sw_rdata <= 32'h0000_0000;
      end
      else if (sw_rd)
      begin
         unique case (sw_addr)
            `SCBH_OFS_ADDR:   sw_rdata <= addr_q;
            `SCBH_OFS_WDATA:  sw_rdata <= wdata_q;
            `SCBH_OFS_CTRL:   sw_rdata <= {25'h0, burst_q, kind_q,
                                           size_q, read_q, 1'b0};
            `SCBH_OFS_STATUS: sw_rdata <= {29'h0, err_q, done_q,
                              state_q != scbh_pkg::SCBH_IDLE};
            `SCBH_OFS_RDATA:  sw_rdata <= burst_q ? buf_rd : rdata_q;
            `SCBH_OFS_CSBASE: sw_rdata <= {24'h0, csbase_q};
            `SCBH_OFS_CSCFG:  sw_rdata <= {22'h0, cfg_q};
            default:          sw_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : scbh_host
`default_nettype wire

// ==== design/scbh_pkg.sv ====
`default_nettype none
package scbh_pkg;
   typedef enum logic [4:0] {
      SCBH_IDLE  = 5'b00001,
      SCBH_START = 5'b00010,
      SCBH_WAIT  = 5'b00100,
      SCBH_ACKED = 5'b01000,
      SCBH_DONE  = 5'b10000
   } scbh_state_type;
   typedef enum logic [1:0] {
      SCBH_SZ_32 = 2'h0,
      SCBH_SZ_8  = 2'h1,
      SCBH_SZ_16 = 2'h2,
      SCBH_SZ_LN = 2'h3
   } scbh_size_type;
endpackage : scbh_pkg
`default_nettype wire

// ==== design/scbh_regs.svh ====
`ifndef SCBH_REGS_SVH
`define SCBH_REGS_SVH
// software-side register offsets (word index on the command port)
`define SCBH_OFS_ADDR      4'h0
`define SCBH_OFS_WDATA     4'h1
`define SCBH_OFS_CTRL      4'h2
`define SCBH_OFS_STATUS    4'h3
`define SCBH_OFS_RDATA     4'h4
`define SCBH_OFS_CSBASE    4'h5
`define SCBH_OFS_CSCFG     4'h6
// control register fields
`define SCBH_CTRL_GO       0
`define SCBH_CTRL_READ     1
`define SCBH_CTRL_SIZE_LO  2
`define SCBH_CTRL_KIND_LO  4
`define SCBH_CTRL_BURST    6
// chip select config fields
`define SCBH_CFG_WS_LO     0
`define SCBH_CFG_EXTACK    4
`define SCBH_CFG_BURST_EN  5
`define SCBH_CFG_WPROT     6
`define SCBH_CFG_VALID     7
`define SCBH_CFG_PS_LO     8
// status fields
`define SCBH_ST_BUSY       0
`define SCBH_ST_DONE       1
`define SCBH_ST_ERR        2
// reset values
`define SCBH_CSBASE_RST    8'h00
`define SCBH_CSCFG_RST     10'h080
// timing: timeout for external acknowledge, ns
`define SCBH_ACK_TMO_NS    2000
`define SCBH_CLK_NS        20
`define SCBH_ACK_TMO_CYC   (`SCBH_ACK_TMO_NS / `SCBH_CLK_NS)
// burst beats and fixed select block bits (2M bytes)
`define SCBH_BURST_BEATS   3'h4
`define SCBH_BLK_BITS      21
`endif

// ==== tb/scbh_host_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// bus-side protocol watcher for the host port
module scbh_host_asserts
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // bus outputs and ack
   input  wire logic [31:0] bus_addr,
   input  wire logic        bus_doe,
   input  wire logic        transfer_start_n,
   input  wire logic        bus_rd_wr,
   input  wire logic        cycle_active,
   input  wire logic        transfer_ack_n,
   input  wire logic [7:0]  chip_sel_n,
   input  wire logic        out_enable_n,
   input  wire logic [3:0]  byte_write_strobe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_start_one_clk: assert property (
      !transfer_start_n |=> transfer_start_n)
      else $error("start strobe longer than one clock");
   a_tip_covers_start: assert property (
      !transfer_start_n |-> cycle_active)
      else $error("start without cycle active");
   a_two_clk_min: assert property (
      $fell(transfer_start_n) |=> cycle_active)
      else $error("cycle shorter than two clocks");
   a_no_start_ack: assert property (
      !transfer_ack_n |-> transfer_start_n)
      else $error("start while ack asserted");
   // address may move only after an acked beat
   a_addr_hold: assert property (
      cycle_active && $past(cycle_active)
      && $past(transfer_ack_n) |-> $stable(bus_addr))
      else $error("address moved inside a beat");
   a_doe_write: assert property (
      bus_doe |-> !bus_rd_wr)
      else $error("data driven during read");
   a_sel_onehot: assert property (
      $onehot0(~chip_sel_n))
      else $error("more than one select low");
   a_sel_in_cycle: assert property (
      chip_sel_n != 8'hff |-> cycle_active || $past(cycle_active))
      else $error("select low outside a cycle");
   a_oe_read: assert property (
      !out_enable_n |-> bus_rd_wr)
      else $error("output enable on a write");
   a_bws_write: assert property (
      byte_write_strobe_n != 4'hf |-> !bus_rd_wr)
      else $error("write strobe on a read");
endmodule : scbh_host_asserts

bind scbh_host scbh_host_asserts u_scbh_host_asserts
(
   .clk_sys             (clk_sys),
   .rst_n               (rst_n),
   .bus_addr            (bus_addr),
   .bus_doe             (bus_doe),
   .transfer_start_n    (transfer_start_n),
   .bus_rd_wr           (bus_rd_wr),
   .cycle_active        (cycle_active),
   .transfer_ack_n      (transfer_ack_n),
   .chip_sel_n          (chip_sel_n),
   .out_enable_n        (out_enable_n),
   .byte_write_strobe_n (byte_write_strobe_n)
);
`default_nettype wire

// ==== tb/scbh_target_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// target peripheral on the selects, acks after a set delay
module scbh_target_model
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // strap and ack delay
   input  wire logic        hold_polarity_strap,
   input  wire logic [4:0]  lat,
   // bus side
   input  wire logic        sel_n,
   input  wire logic        cycle_active,
   input  wire logic        bus_rd_wr,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_dout,
   output logic      [31:0] bus_din,
   output logic             wait_pin
);
   logic        strap_q;
   logic        ack_q;
   logic [4:0]  cnt_q;
   logic [31:0] last_q;
   logic [31:0] mem [16];
   logic [3:0]  idx;
   // bit 17 picks register or buffer block
   assign idx = {bus_addr[17], bus_addr[4:2]};
   // strap taken as reset lets go
   always_ff @(posedge rst_n)
      strap_q <= hold_polarity_strap;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         cnt_q <= 5'h00;
      end
      else if (ack_q)
      begin
         ack_q <= 1'b0;
         cnt_q <= 5'h00;
      end
      else if (cycle_active && !sel_n)
      begin
         if (cnt_q == lat)
            ack_q <= 1'b1;
         else
            cnt_q <= cnt_q + 5'h01;
      end
      else
         cnt_q <= 5'h00;
   end
   // store on acked writes; data line never keeps a stale value
   always_ff @(posedge clk_sys)
   begin
      if (ack_q && !bus_rd_wr)
         mem[idx] <= bus_dout;
      last_q <= bus_din;
   end
   assign bus_din = (ack_q && bus_rd_wr) ? mem[idx] : ~last_q;
   assign wait_pin = strap_q ? ~ack_q : ack_q;
endmodule : scbh_target_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scbh_regs.svh"
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [4:0]  lat = 5'h00;
   logic [31:0] sw_rdata, bus_addr, bus_dout, bus_din, st_addr;
   logic        bus_doe, transfer_start_n, bus_rd_wr, cycle_active;
   logic        transfer_ack_n, out_enable_n;
   logic [1:0]  xfer_size_code, xfer_kind_code;
   logic [7:0]  chip_sel_n, sel_and;
   logic [3:0]  byte_write_strobe_n;
   logic [4:0]  st_ctl;
   logic [2:0]  stb_and;
   int          n_tip = 0;
   int          n_fail = 0;
   int          total_checks = 0;
   int          n_start = 0;
   int          n_ack = 0;

   always #10 clk_sys = ~clk_sys;

   scbh_host #(.ACK_TMO(16)) u_scbh_host
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .bus_addr(bus_addr), .bus_dout(bus_dout),
      .bus_doe(bus_doe), .bus_din(bus_din),
      .transfer_start_n(transfer_start_n),
      .xfer_size_code(xfer_size_code), .xfer_kind_code(xfer_kind_code),
      .bus_rd_wr(bus_rd_wr), .cycle_active(cycle_active),
      .transfer_ack_n(transfer_ack_n), .chip_sel_n(chip_sel_n),
      .out_enable_n(out_enable_n),
      .byte_write_strobe_n(byte_write_strobe_n)
   );

   scbh_target_model u_scbh_target_model
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .hold_polarity_strap(1'b1),
      .lat(lat), .sel_n(&chip_sel_n), .cycle_active(cycle_active),
      .bus_rd_wr(bus_rd_wr), .bus_addr(bus_addr), .bus_dout(bus_dout),
      .bus_din(bus_din), .wait_pin(transfer_ack_n)
   );

   // bus watcher: starts, acks and selects seen per transfer
   always @(posedge clk_sys)
   begin
      if (!transfer_start_n)
      begin
         n_start++;
         st_addr = bus_addr;
         st_ctl = {bus_rd_wr, xfer_size_code, xfer_kind_code};
      end
      if (!transfer_ack_n)
         n_ack++;
      sel_and = sel_and & chip_sel_n;
      if (cycle_active)
         n_tip++;
      // read enable, any byte strobe, data drive seen in a transfer
      stb_and = stb_and & {out_enable_n, &byte_write_strobe_n, !bus_doe};
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // gap cycle after each strobe keeps drivers race free
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk_sys);
      sw_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] i,
                     output logic [31:0] v);
      sw_addr <= a;
      sw_wdata <= i;
      sw_rd <= 1'b1;
      @(posedge clk_sys);
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
      @(posedge clk_sys);
   endtask : rd

   // launch, poll status under a bound, then clear it
   task automatic txn(input logic [31:0] ctrl, output logic [31:0] st);
      int i;
      sel_and = 8'hff;
      stb_and = 3'h7;
      wr(`SCBH_OFS_CTRL, ctrl);
      for (i = 0; i < 100; i++)
      begin
         rd(`SCBH_OFS_STATUS, 32'h0, st);
         if (st[`SCBH_ST_DONE] || st[`SCBH_ST_ERR])
            break;
      end
      wr(`SCBH_OFS_STATUS, 32'h0);
      if (i == 100)
      begin
         n_fail++;
         results();
      end
   endtask : txn

   task automatic t_reset();
      logic [31:0] v;
      chk({22'h0, cycle_active, transfer_start_n, chip_sel_n}, 32'h1ff);
      rd(`SCBH_OFS_CSCFG, 32'h0, v);
      chk(v, 32'h080);
      rd(`SCBH_OFS_CSBASE, 32'h0, v);
      chk(v, 32'h0);
   endtask : t_reset

   // every slot, both blocks, all kinds, sizes 0 to 2; pass 1 reads back
   task automatic t_slots();
      logic [31:0] a, d, st;
      wr(`SCBH_OFS_CSBASE, 32'h40);
      wr(`SCBH_OFS_CSCFG, 32'h0b0);
      for (int p = 0; p < 2; p++)
         for (int s = 0; s < 6; s++)
            for (int b = 0; b < 2; b++)
            begin
               a = 32'h4000_0000 | (s << 21) | (b << 17) | (s << 2);
               d = 32'hc0de_0000 + 32'(s * 2 + b);
               lat <= 5'(s);
               wr(`SCBH_OFS_ADDR, a);
               wr(`SCBH_OFS_WDATA, d);
               txn({25'h0, 1'b0, 2'(s), 2'(s % 3), 1'(p), 1'b1}, st);
               chk(st, 32'h2);
               chk(st_addr, a);
               chk({27'h0, st_ctl}, {27'h0, 1'(p), 2'(s % 3), 2'(s)});
               chk({24'h0, sel_and}, {24'h0, ~(8'h01 << (s + 2))});
               chk({29'h0, stb_and}, p ? 32'h3 : 32'h4);
               if (p == 1)
               begin
                  rd(`SCBH_OFS_RDATA, 32'h0, st);
                  chk(st, d);
               end
            end
   endtask : t_slots

   task automatic t_burst();
      logic [31:0] v;
      int          n0;
      n0 = n_ack;
      lat <= 5'h01;
      wr(`SCBH_OFS_ADDR, 32'h4000_0000);
      txn({25'h0, 1'b1, 2'h0, 2'h3, 1'b1, 1'b1}, v);
      chk(32'(n_ack - n0), 32'h4);
      // store read is registered: the index must stand a cycle ahead
      for (int j = 0; j < 4; j++)
      begin
         rd(`SCBH_OFS_RDATA, 32'(j), v);
         rd(`SCBH_OFS_RDATA, 32'(j), v);
         chk(v, 32'hc0de_0000 + 32'(j * 2));
      end
   endtask : t_burst

   // internal waits, silent target: start, ws waits, then the end beat
   task automatic t_waits();
      logic [31:0] ws [3] = '{32'h0, 32'h3, 32'hf};
      logic [31:0] v;
      int          n0;
      lat <= 5'h1f;
      wr(`SCBH_OFS_ADDR, 32'h4000_0000);
      for (int k = 0; k < 3; k++)
      begin
         wr(`SCBH_OFS_CSCFG, 32'h0a0 | ws[k]);
         n0 = n_tip;
         txn(32'h1, v);
         chk(v, 32'h2);
         chk(32'(n_tip - n0), ws[k] + 32'h2);
      end
   endtask : t_waits

   // write protect, burst barred, no hit, then a silent target
   task automatic t_refuse();
      logic [31:0] cfg [4] = '{32'h0f0, 32'h090, 32'h0b0, 32'h0b0};
      logic [31:0] adr [4] = '{32'h4000_0000, 32'h4000_0000,
                               32'h8000_0000, 32'h4000_0000};
      logic [31:0] v;
      int          n0;
      for (int i = 0; i < 4; i++)
      begin
         n0 = n_start;
         lat <= (i == 3) ? 5'h1f : 5'h00;
         wr(`SCBH_OFS_CSCFG, cfg[i]);
         wr(`SCBH_OFS_ADDR, adr[i]);
         txn((i == 1) ? 32'h4f : 32'h1, v);
         chk({31'h0, v[`SCBH_ST_ERR]}, 32'h1);
         chk(32'(n_start - n0), (i == 3) ? 32'h1 : 32'h0);
      end
   endtask : t_refuse

   initial
   begin
      sel_and = 8'hff;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_slots();
      t_burst();
      t_waits();
      t_refuse();
      results();
   end
endmodule : tb
`default_nettype wire
